// ==== hw/pifer_top.v ====
// Peripheral interrupt flag registers two and three, enable registers one and two, and request logic.
//
// What this block does
// - Oscillator failure with switch to internal RC sets flag two bit 7, sticky.
// - A comparator input change sets flag two bit 6 until software clears it.
// - Any network module event sets flag two bit 5; source lives elsewhere.
// - Bit 2 of flag two and enable two reads zero, writes ignored.
// - First serial module bus collision sets flag two bit 3, sticky.
// - Third timer overflow sets flag two bit 1 until software clears it.
// - Second capture/compare event sets flag two bit 0, not in PWM mode.
// - Second serial module transfer done sets flag three bit 7, sticky.
// - Second serial module bus collision sets flag three bit 6, sticky.
// - Flag three bit 5 is read-only, shows receive buffer full, resets zero.
// - Flag three bit 4 is read-only, shows transmit buffer empty.
// - Fourth timer matching its period sets flag three bit 3, sticky.
// - Capture/compare units five, four, three set flag three bits 2..0.
// - Without priority levels, requests need the peripheral group enable too.
// - Enable register one holds eight read/write enables, one enables.
// - Enable register two holds enables at bits 7,6,5,4,3,1,0.
// - All flag and enable bits clear to zero on reset.
// - Flags set on their event regardless of any enable, for polling.
// - Priority enable selects prioritised levels or single-level scheme.
`timescale 1ns/1ps
`default_nettype none
`include "pifer_regs.vh"

module pifer_top #(
    parameter ADDR_W = 8
) (
    input wire clock_i,
    input wire rst_i,

    // ------------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------------
    input wire [ADDR_W-1:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    output wire [1:0] s_axi_bresp_o,
    output wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [ADDR_W-1:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0] s_axi_rresp_o,
    output wire s_axi_rvalid_o,
    input wire s_axi_rready_i,

    // ------------------------------------------------------------------------
    // Peripheral event sources
    // ------------------------------------------------------------------------
    input wire osc_fail_event_i,
    input wire comparator_change_event_i,
    input wire network_event_i,
    input wire bus_collision_a_event_i,
    input wire timer_c_overflow_event_i,
    input wire capcmp_b_event_i,
    input wire capcmp_b_pwm_mode_i,
    input wire sync_serial_b_done_i,
    input wire bus_collision_b_event_i,
    input wire serial_b_rx_full_i,
    input wire serial_b_tx_empty_i,
    input wire timer_d_match_event_i,
    input wire capcmp_e_event_i,
    input wire capcmp_e_pwm_mode_i,
    input wire capcmp_d_event_i,
    input wire capcmp_d_pwm_mode_i,
    input wire capcmp_c_event_i,
    input wire capcmp_c_pwm_mode_i,

    // ------------------------------------------------------------------------
    // Neighbouring interrupt registers
    // ------------------------------------------------------------------------
    input wire [7:0] periph_irq_flags_a_i,
    input wire [7:0] periph_irq_enables_c_i,
    input wire peripheral_group_irq_en_i,
    input wire priority_levels_en_i,

    // ------------------------------------------------------------------------
    // Outputs to the core and neighbours
    // ------------------------------------------------------------------------
    output reg [7:0] periph_irq_flags_b_o,
    output reg [7:0] periph_irq_flags_c_o,
    output reg [7:0] periph_irq_enables_a_o,
    output reg [7:0] periph_irq_enables_b_o,
    output reg periph_irq_req_o
);

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    wire [7:0] periph_irq_flags_b;
    wire [7:0] periph_irq_flags_c;
    reg [7:0] periph_irq_enables_a;
    reg [7:0] periph_irq_enables_b;
    reg [7:0] next_enables_a;
    reg [7:0] next_enables_b;
    wire [7:0] flags_b_set;
    wire [7:0] flags_c_set;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    wire wr_en;
    wire wr_lane0;
    wire [7:0] wr_byte;
    wire [7:0] wr_addr_word;
    wire [7:0] rd_addr_word;
    wire wr_upper_zero;
    wire rd_upper_zero;
    reg wr_hit;
    reg rd_hit;
    reg [7:0] rd_byte;
    wire [31:0] rd_data;
    wire wr_flags_b;
    wire wr_flags_c;
    wire wr_enables_a;
    wire wr_enables_b;

    // Only byte lane 0 carries register data; upper lanes are accepted and dropped.
    assign wr_lane0 = wr_en & wr_hit & s_axi_wstrb_i[0];
    assign wr_byte = s_axi_wdata_i[7:0];
    assign wr_addr_word = {s_axi_awaddr_i[7:`PIFER_WORD_LSB], 2'b00};
    assign rd_addr_word = {s_axi_araddr_i[7:`PIFER_WORD_LSB], 2'b00};

    generate
        if (ADDR_W > 8) begin : g_upper
            assign wr_upper_zero = ~|s_axi_awaddr_i[ADDR_W-1:8];
            assign rd_upper_zero = ~|s_axi_araddr_i[ADDR_W-1:8];
        end else begin : g_no_upper
            assign wr_upper_zero = 1'b1;
            assign rd_upper_zero = 1'b1;
        end
    endgenerate

    always @* begin
        case (wr_addr_word)
            `PIFER_OFF_FLAGS_B, `PIFER_OFF_FLAGS_C, `PIFER_OFF_ENABLES_A, `PIFER_OFF_ENABLES_B: wr_hit = wr_upper_zero;
            default: wr_hit = 1'b0;
        endcase
    end

    // Bit 2 of both register-two images is forced low at the source, so reads need no masking.
    always @* begin
        rd_hit = rd_upper_zero;
        case (rd_addr_word)
            `PIFER_OFF_FLAGS_B: rd_byte = periph_irq_flags_b;
            `PIFER_OFF_FLAGS_C: rd_byte = periph_irq_flags_c;
            `PIFER_OFF_ENABLES_A: rd_byte = periph_irq_enables_a;
            `PIFER_OFF_ENABLES_B: rd_byte = periph_irq_enables_b;
            default: begin
                rd_byte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    assign rd_data = {24'h0, rd_byte};

    assign wr_flags_b = wr_lane0 & (wr_addr_word == `PIFER_OFF_FLAGS_B);
    assign wr_flags_c = wr_lane0 & (wr_addr_word == `PIFER_OFF_FLAGS_C);
    assign wr_enables_a = wr_lane0 & (wr_addr_word == `PIFER_OFF_ENABLES_A);
    assign wr_enables_b = wr_lane0 & (wr_addr_word == `PIFER_OFF_ENABLES_B);

    pifer_axil_slave #(
        .ADDR_W(ADDR_W)
    ) u_bus (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .s_axi_awaddr_i(s_axi_awaddr_i),
        .s_axi_awvalid_i(s_axi_awvalid_i),
        .s_axi_awready_o(s_axi_awready_o),
        .s_axi_wdata_i(s_axi_wdata_i),
        .s_axi_wstrb_i(s_axi_wstrb_i),
        .s_axi_wvalid_i(s_axi_wvalid_i),
        .s_axi_wready_o(s_axi_wready_o),
        .s_axi_bresp_o(s_axi_bresp_o),
        .s_axi_bvalid_o(s_axi_bvalid_o),
        .s_axi_bready_i(s_axi_bready_i),
        .s_axi_araddr_i(s_axi_araddr_i),
        .s_axi_arvalid_i(s_axi_arvalid_i),
        .s_axi_arready_o(s_axi_arready_o),
        .s_axi_rdata_o(s_axi_rdata_o),
        .s_axi_rresp_o(s_axi_rresp_o),
        .s_axi_rvalid_o(s_axi_rvalid_o),
        .s_axi_rready_i(s_axi_rready_i),
        .wr_hit_i(wr_hit),
        .rd_hit_i(rd_hit),
        .rd_data_i(rd_data),
        .wr_en_o(wr_en)
    );

    // ------------------------------------------------------------------------
    // Flag sources
    // ------------------------------------------------------------------------
    // Sources are on this clock, so no synchroniser; enables never gate a set.
    assign flags_b_set[7] = osc_fail_event_i;
    assign flags_b_set[6] = comparator_change_event_i;
    assign flags_b_set[5] = network_event_i;
    assign flags_b_set[`PIFER_BIT_RESERVED] = 1'b0;
    assign flags_b_set[3] = bus_collision_a_event_i;
    assign flags_b_set[`PIFER_BIT_UNIMPL] = 1'b0;
    assign flags_b_set[1] = timer_c_overflow_event_i;
    assign flags_b_set[0] = capcmp_b_event_i & ~capcmp_b_pwm_mode_i;

    assign flags_c_set[7] = sync_serial_b_done_i;
    assign flags_c_set[6] = bus_collision_b_event_i;
    assign flags_c_set[`PIFER_BIT_RX_FULL] = serial_b_rx_full_i;
    assign flags_c_set[`PIFER_BIT_TX_EMPTY] = serial_b_tx_empty_i;
    assign flags_c_set[3] = timer_d_match_event_i;
    assign flags_c_set[2] = capcmp_e_event_i & ~capcmp_e_pwm_mode_i;
    assign flags_c_set[1] = capcmp_d_event_i & ~capcmp_d_pwm_mode_i;
    assign flags_c_set[0] = capcmp_c_event_i & ~capcmp_c_pwm_mode_i;

    localparam [7:0] B_WR = `PIFER_FLAGS_B_WR_MASK;
    localparam [7:0] C_WR = `PIFER_FLAGS_C_WR_MASK;
    localparam [7:0] C_FOLLOW = `PIFER_FLAGS_C_FOLLOW_MASK;

    // ------------------------------------------------------------------------
    // Flag registers
    // ------------------------------------------------------------------------
    // The buffer-state bits follow their serial module level, which drops itself
    // when the buffer is read or written; software writes to them are ignored.
    genvar i;
    generate
        for (i = 0; i < `PIFER_REG_W; i = i + 1) begin : g_flags
            pifer_flag_bit #(
                .WRITABLE(B_WR[i]),
                .FOLLOW(1'b0)
            ) u_flag_b (
                .clock_i(clock_i),
                .rst_i(rst_i),
                .set_i(flags_b_set[i]),
                .wr_i(wr_flags_b),
                .wr_data_i(wr_byte[i] & B_WR[i]),
                .flag_o(periph_irq_flags_b[i])
            );
            pifer_flag_bit #(
                .WRITABLE(C_WR[i]),
                .FOLLOW(C_FOLLOW[i])
            ) u_flag_c (
                .clock_i(clock_i),
                .rst_i(rst_i),
                .set_i(flags_c_set[i]),
                .wr_i(wr_flags_c & ~C_FOLLOW[i]),
                .wr_data_i(wr_byte[i] & C_WR[i]),
                .flag_o(periph_irq_flags_c[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Enable registers
    // ------------------------------------------------------------------------
    always @* begin
        next_enables_a = periph_irq_enables_a;
        next_enables_b = periph_irq_enables_b;
        if (wr_enables_a) begin
            next_enables_a = wr_byte;
        end
        if (wr_enables_b) begin
            next_enables_b = wr_byte & `PIFER_ENABLES_B_WR_MASK;
        end
    end

    always @(posedge clock_i) begin
        if (rst_i) begin
            periph_irq_enables_a <= `PIFER_RESET_VALUE;
            periph_irq_enables_b <= `PIFER_RESET_VALUE;
        end else begin
            periph_irq_enables_a <= next_enables_a;
            periph_irq_enables_b <= next_enables_b;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------------------
    // The request is registered, so it trails the flag by one clock; the core
    // samples it at instruction boundaries, which hides that cycle.
    wire any_pending;
    wire group_gate;

    assign any_pending = |(periph_irq_flags_a_i & periph_irq_enables_a)
                       | |(periph_irq_flags_b & periph_irq_enables_b)
                       | |(periph_irq_flags_c & periph_irq_enables_c_i);

    // With priority levels on, per-source priority routing happens downstream.
    assign group_gate = priority_levels_en_i | peripheral_group_irq_en_i;

    always @(posedge clock_i) begin
        if (rst_i) begin
            periph_irq_req_o <= 1'b0;
            periph_irq_flags_b_o <= `PIFER_RESET_VALUE;
            periph_irq_flags_c_o <= `PIFER_RESET_VALUE;
            periph_irq_enables_a_o <= `PIFER_RESET_VALUE;
            periph_irq_enables_b_o <= `PIFER_RESET_VALUE;
        end else begin
            periph_irq_req_o <= any_pending & group_gate;
            periph_irq_flags_b_o <= periph_irq_flags_b;
            periph_irq_flags_c_o <= periph_irq_flags_c;
            periph_irq_enables_a_o <= periph_irq_enables_a;
            periph_irq_enables_b_o <= periph_irq_enables_b;
        end
    end

endmodule
`default_nettype wire

// ==== hw/pifer_regs.vh ====
// Register map, field positions and bus codes for the peripheral interrupt flag and enable block.
`ifndef PIFER_REGS_VH
`define PIFER_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PIFER_OFF_FLAGS_B 8'h00
`define PIFER_OFF_FLAGS_C 8'h04
`define PIFER_OFF_ENABLES_A 8'h08
`define PIFER_OFF_ENABLES_B 8'h0c

// ----------------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------------
`define PIFER_REG_W 8
`define PIFER_RESET_VALUE 8'h00
`define PIFER_BIT_UNIMPL 2
`define PIFER_BIT_RESERVED 4
`define PIFER_BIT_RX_FULL 5
`define PIFER_BIT_TX_EMPTY 4
`define PIFER_FLAGS_B_WR_MASK 8'hfb
`define PIFER_FLAGS_C_WR_MASK 8'hcf
`define PIFER_FLAGS_C_FOLLOW_MASK 8'h30
`define PIFER_ENABLES_B_WR_MASK 8'hfb
`define PIFER_WORD_LSB 2

// ----------------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------------
`define PIFER_RESP_OKAY 2'b00
`define PIFER_RESP_SLVERR 2'b10

`endif

// ==== hw/pifer_flag_bit.v ====
// One interrupt flag bit: sticky with software write, or a level that follows its source.
`timescale 1ns/1ps
`default_nettype none
`include "pifer_regs.vh"

module pifer_flag_bit #(
    parameter [0:0] WRITABLE = 1'b1,
    parameter [0:0] FOLLOW = 1'b0
) (
    input wire clock_i,
    input wire rst_i,
    input wire set_i,
    input wire wr_i,
    input wire wr_data_i,
    output reg flag_o
);

    reg next_flag;

    // The event is ORed in after the write, so a set in the clearing cycle is kept.
    always @* begin
        if (FOLLOW) begin
            next_flag = set_i;
        end else if (wr_i && WRITABLE) begin
            next_flag = wr_data_i | set_i;
        end else begin
            next_flag = flag_o | set_i;
        end
    end

    always @(posedge clock_i) begin
        if (rst_i) begin
            flag_o <= 1'b0;
        end else begin
            flag_o <= next_flag;
        end
    end

endmodule
`default_nettype wire

// ==== hw/pifer_axil_slave.v ====
// AXI4-Lite slave handshake engine; register decode and storage stay with the caller.
`timescale 1ns/1ps
`default_nettype none
`include "pifer_regs.vh"

module pifer_axil_slave #(
    parameter ADDR_W = 8
) (
    input wire clock_i,
    input wire rst_i,
    input wire [ADDR_W-1:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output reg s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output reg s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [ADDR_W-1:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output reg s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    input wire wr_hit_i,
    input wire rd_hit_i,
    input wire [31:0] rd_data_i,
    output wire wr_en_o
);

    // Address and data are taken together, so the caller sees one write strobe.
    assign wr_en_o = s_axi_awready_o & s_axi_awvalid_i & s_axi_wvalid_i;

    always @(posedge clock_i) begin
        if (rst_i) begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `PIFER_RESP_OKAY;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rresp_o <= `PIFER_RESP_OKAY;
            s_axi_rdata_o <= 32'h0;
        end else begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            if (!s_axi_awready_o && !s_axi_bvalid_o && s_axi_awvalid_i && s_axi_wvalid_i) begin
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
            if (wr_en_o) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_hit_i ? `PIFER_RESP_OKAY : `PIFER_RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
            s_axi_arready_o <= !s_axi_arready_o && !s_axi_rvalid_o && s_axi_arvalid_i;
            if (s_axi_arready_o && s_axi_arvalid_i) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= rd_hit_i ? rd_data_i : 32'h0;
                s_axi_rresp_o <= rd_hit_i ? `PIFER_RESP_OKAY : `PIFER_RESP_SLVERR;
            end else if (s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ==== verif/pifer_checker.sv ====
// Concurrent property checker for the peripheral interrupt flag and enable block.
`timescale 1ns/1ps
`default_nettype none
module pifer_checker (
    input wire clock_i,
    input wire rst_i,
    input wire s_axi_awvalid_i,
    input wire s_axi_wvalid_i,
    input wire s_axi_awready_o,
    input wire s_axi_wready_o,
    input wire s_axi_bvalid_o,
    input wire osc_fail_event_i,
    input wire comparator_change_event_i,
    input wire timer_c_overflow_event_i,
    input wire serial_b_rx_full_i,
    input wire serial_b_tx_empty_i,
    input wire [7:0] periph_irq_flags_a_i,
    input wire [7:0] periph_irq_enables_c_i,
    input wire peripheral_group_irq_en_i,
    input wire priority_levels_en_i,
    input wire [7:0] periph_irq_flags_b_o,
    input wire [7:0] periph_irq_flags_c_o,
    input wire [7:0] periph_irq_enables_a_o,
    input wire [7:0] periph_irq_enables_b_o,
    input wire periph_irq_req_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    sequence s_wr_take;
        s_axi_awvalid_i && s_axi_wvalid_i ##1 s_axi_awready_o && s_axi_wready_o;
    endsequence
    sequence s_clean;
        !$past(rst_i) && !$past(rst_i, 2);
    endsequence
    property p_wr_resp;
        s_wr_take |=> s_axi_bvalid_o;
    endproperty
    property p_osc;
        osc_fail_event_i |-> ##2 periph_irq_flags_b_o[7];
    endproperty
    property p_cmp;
        comparator_change_event_i |-> ##2 periph_irq_flags_b_o[6];
    endproperty
    property p_tmr;
        timer_c_overflow_event_i |-> ##2 periph_irq_flags_b_o[1];
    endproperty
    property p_unimpl;
        !periph_irq_flags_b_o[2] && !periph_irq_enables_b_o[2];
    endproperty
    property p_rx;
        s_clean |-> periph_irq_flags_c_o[5] == $past(serial_b_rx_full_i, 2);
    endproperty
    property p_tx;
        s_clean |-> periph_irq_flags_c_o[4] == $past(serial_b_tx_empty_i, 2);
    endproperty
    property p_sticky;
        s_clean and $fell(periph_irq_flags_c_o[3]) |-> $past(s_axi_wready_o, 2);
    endproperty
    property p_req;
        !$past(rst_i) |-> periph_irq_req_o == ((|(periph_irq_flags_b_o & periph_irq_enables_b_o)
            || |(periph_irq_flags_c_o & $past(periph_irq_enables_c_i))
            || |($past(periph_irq_flags_a_i) & periph_irq_enables_a_o))
            && ($past(priority_levels_en_i) || $past(peripheral_group_irq_en_i)));
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
    a_osc: assert property (p_osc) else $error("oscillator flag not set");
    a_cmp: assert property (p_cmp) else $error("comparator flag not set");
    a_tmr: assert property (p_tmr) else $error("timer flag not set");
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");
    a_rx: assert property (p_rx) else $error("receive full flag wrong");
    a_tx: assert property (p_tx) else $error("transmit empty flag wrong");
    a_sticky: assert property (p_sticky) else $error("flag dropped without write");
    a_req: assert property (p_req) else $error("request level wrong");
endmodule
bind pifer_top pifer_checker i_pifer_checker (.clock_i(clock_i), .rst_i(rst_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o), .osc_fail_event_i(osc_fail_event_i),
    .comparator_change_event_i(comparator_change_event_i), .timer_c_overflow_event_i(timer_c_overflow_event_i),
    .serial_b_rx_full_i(serial_b_rx_full_i), .serial_b_tx_empty_i(serial_b_tx_empty_i),
    .periph_irq_flags_a_i(periph_irq_flags_a_i), .periph_irq_enables_c_i(periph_irq_enables_c_i),
    .peripheral_group_irq_en_i(peripheral_group_irq_en_i), .priority_levels_en_i(priority_levels_en_i),
    .periph_irq_flags_b_o(periph_irq_flags_b_o), .periph_irq_flags_c_o(periph_irq_flags_c_o),
    .periph_irq_enables_a_o(periph_irq_enables_a_o), .periph_irq_enables_b_o(periph_irq_enables_b_o),
    .periph_irq_req_o(periph_irq_req_o));
`default_nettype wire

// ==== verif/pifer_event_model.sv ====
// Behavioural model of the peripheral event sources and the second serial port buffers.
`timescale 1ns/1ps
`default_nettype none
module pifer_event_model (
    input wire logic clock_i,
    input wire logic fire_i,
    input wire logic [3:0] sel_i,
    input wire logic [1:0] buf_set_i,
    input wire logic [1:0] buf_clr_i,
    output logic [11:0] event_o,
    output logic [1:0] buf_o
);
    // Events are one-cycle pulses, so a flag that stays up proves the block holds it.
    initial event_o = 12'h000;
    initial buf_o = 2'b00;
    always @(posedge clock_i) begin
        event_o <= fire_i ? 12'h001 << sel_i : 12'h000;
        buf_o <= (buf_o | buf_set_i) & ~buf_clr_i;
    end
endmodule
`default_nettype wire

// ==== verif/peripheral_irq_flag_enable_regs_bench.sv ====
// Self-checking bench for the peripheral interrupt flag and enable block.
`timescale 1ns/1ps
`default_nettype none
`include "pifer_regs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module peripheral_irq_flag_enable_regs_bench;
    logic clock_i = 0, rst_i = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic fire = 0, group_en = 0, prio_en = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] sel = 0, pwm = 0;
    logic [1:0] bset = 0, bclr = 0;
    logic [15:0] lfsr_s = 16'hdd11;
    logic [33:0] notes[$], exp_n;
    int fails = 0, n_checks = 0, cyc = 0;
    int pos[12] = '{7, 6, 5, 3, 1, 0, 7, 6, 3, 2, 1, 0};
    wire awready, wready, bvalid, arready, rvalid, req;
    wire [1:0] bresp, rresp, bufs;
    wire [31:0] rdata;
    wire [11:0] ev;
    pifer_event_model i_pifer_event_model (.clock_i(clock_i), .fire_i(fire), .sel_i(sel), .buf_set_i(bset),
        .buf_clr_i(bclr), .event_o(ev), .buf_o(bufs));
    pifer_top i_pifer_top (.clock_i(clock_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .osc_fail_event_i(ev[0]),
        .comparator_change_event_i(ev[1]), .network_event_i(ev[2]), .bus_collision_a_event_i(ev[3]),
        .timer_c_overflow_event_i(ev[4]), .capcmp_b_event_i(ev[5]), .capcmp_b_pwm_mode_i(pwm[0]),
        .sync_serial_b_done_i(ev[6]), .bus_collision_b_event_i(ev[7]), .serial_b_rx_full_i(bufs[1]),
        .serial_b_tx_empty_i(bufs[0]), .timer_d_match_event_i(ev[8]), .capcmp_e_event_i(ev[9]),
        .capcmp_e_pwm_mode_i(pwm[1]), .capcmp_d_event_i(ev[10]), .capcmp_d_pwm_mode_i(pwm[2]),
        .capcmp_c_event_i(ev[11]), .capcmp_c_pwm_mode_i(pwm[3]), .periph_irq_flags_a_i(8'h00),
        .periph_irq_enables_c_i(8'h00), .peripheral_group_irq_en_i(group_en), .priority_levels_en_i(prio_en),
        .periph_irq_flags_b_o(), .periph_irq_flags_c_o(), .periph_irq_enables_a_o(), .periph_irq_enables_b_o(),
        .periph_irq_req_o(req));
    initial begin
        forever #25 clock_i = ~clock_i;
    end
    function automatic logic [7:0] lfsr();
        lfsr_s = {lfsr_s[14:0], lfsr_s[15] ^ lfsr_s[13] ^ lfsr_s[12] ^ lfsr_s[10]};
        return lfsr_s[7:0];
    endfunction
    task automatic conclude();
        if (fails == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        notes.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        @(posedge clock_i);
        while (!awready) @(posedge clock_i);
        awvalid <= 0;
        wvalid <= 0;
        while (!bvalid) @(posedge clock_i);
        bready <= 0;
        @(posedge clock_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        notes.push_back({r, 24'h0, d});
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        @(posedge clock_i);
        while (!arready) @(posedge clock_i);
        arvalid <= 0;
        while (!rvalid) @(posedge clock_i);
        rready <= 0;
        @(posedge clock_i);
    endtask
    task automatic pulse(input int i, input logic p);
        sel <= i[3:0];
        pwm <= {4{p}};
        fire <= 1;
        @(posedge clock_i);
        fire <= 0;
        repeat (3) @(posedge clock_i);
        pwm <= 0;
    endtask
    always @(posedge clock_i) begin
        if ((bvalid && bready) || (rvalid && rready)) begin
            exp_n = notes.pop_front();
            `CHK(bvalid ? {bresp, 32'h0} : {rresp, rdata}, exp_n)
        end
    end
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        logic [7:0] a, r;
        repeat (16) @(posedge clock_i);
        rst_i <= 0;
        @(posedge clock_i);
        for (int k = 0; k < 16; k += 4) rd(k[7:0], 8'h00, `PIFER_RESP_OKAY);
        rd(8'h10, 8'h00, `PIFER_RESP_SLVERR);
        wr(8'h10, 8'hff, `PIFER_RESP_SLVERR);
        for (int i = 0; i < 12; i++) begin
            a = i < 6 ? `PIFER_OFF_FLAGS_B : `PIFER_OFF_FLAGS_C;
            if (i == 5 || i > 8) begin
                pulse(i, 1);
                rd(a, 8'h00, `PIFER_RESP_OKAY);
            end
            pulse(i, 0);
            rd(a, 8'h01 << pos[i], `PIFER_RESP_OKAY);
            wr(a, 8'h00, `PIFER_RESP_OKAY);
            rd(a, 8'h00, `PIFER_RESP_OKAY);
        end
        for (int k = 0; k < 4; k++) begin
            r = lfsr();
            wr(`PIFER_OFF_ENABLES_A, r, `PIFER_RESP_OKAY);
            rd(`PIFER_OFF_ENABLES_A, r, `PIFER_RESP_OKAY);
            r = (lfsr() | 8'h04) & 8'hef;
            wr(`PIFER_OFF_ENABLES_B, r, `PIFER_RESP_OKAY);
            rd(`PIFER_OFF_ENABLES_B, r & 8'hfb, `PIFER_RESP_OKAY);
        end
        wr(`PIFER_OFF_FLAGS_B, 8'h04, `PIFER_RESP_OKAY);
        rd(`PIFER_OFF_FLAGS_B, 8'h00, `PIFER_RESP_OKAY);
        for (int j = 0; j < 2; j++) begin
            bset[j] <= 1;
            @(posedge clock_i);
            bset[j] <= 0;
            wr(`PIFER_OFF_FLAGS_C, 8'h00, `PIFER_RESP_OKAY);
            rd(`PIFER_OFF_FLAGS_C, 8'h10 << j, `PIFER_RESP_OKAY);
            bclr[j] <= 1;
            @(posedge clock_i);
            bclr[j] <= 0;
            rd(`PIFER_OFF_FLAGS_C, 8'h00, `PIFER_RESP_OKAY);
        end
        wr(`PIFER_OFF_ENABLES_B, 8'h02, `PIFER_RESP_OKAY);
        pulse(4, 0);
        `CHK(req, 1'b0)
        group_en <= 1;
        repeat (3) @(posedge clock_i);
        `CHK(req, 1'b1)
        group_en <= 0;
        prio_en <= 1;
        repeat (3) @(posedge clock_i);
        `CHK(req, 1'b1)
        wr(`PIFER_OFF_FLAGS_B, 8'h00, `PIFER_RESP_OKAY);
        repeat (3) @(posedge clock_i);
        `CHK(req, 1'b0)
        conclude();
    end
endmodule
`default_nettype wire
